/* verilog/dbu_defs.vh */
// register indices, field positions and reset values of the debug breakpoint unit
`ifndef DBU_DEFS_VH
`define DBU_DEFS_VH
`define DBU_IDX_CAUSE    8'h15
`define DBU_IDX_DATA     8'h16
`define DBU_IDX_STOP     8'h18
`define DBU_IDX_SCR      8'h20
`define DBU_IDX_IBA      8'h30
`define DBU_IDX_IBC      8'h40
`define DBU_IDX_DWA1     8'h50
`define DBU_IDX_DWA2     8'h60
`define DBU_IDX_DWC      8'h70
`define DBU_IDX_RWM      8'h80
`define DBU_IDX_RWV      8'h90
`define DBU_IDX_RWC      8'h9C
`define DBU_IDX_STS      8'hA0
`define DBU_IDX_MSK      8'hA1
`define DBU_IDX_MODE     8'hA2
`define DBU_CAUSE_LSB    0
`define DBU_CAUSE_W      3
`define DBU_THR_LSB      8
`define DBU_BIDX_LSB     16
`define DBU_EN_BIT       0
`define DBU_COND_BIT     1
`define DBU_LOAD_BIT     2
`define DBU_TEN_LSB      16
`define DBU_CTL_WMASK    32'h00FF0007
`define DBU_CAUSE_HOST   3'h1
`define DBU_CAUSE_DEBUG_CALL_INSTRUCTION  3'h2
`define DBU_CAUSE_IBP    3'h3
`define DBU_CAUSE_DWP    3'h4
`define DBU_CAUSE_RWP    3'h5
`define DBU_RST_CAUSE    3'h0
`define DBU_RST_CTL      32'h00000000
`define DBU_RST_WORD     32'h00000000
`define DBU_HTRANS_NSEQ  2'h2
`define DBU_HRESP_OKAY   1'h0
`endif

/* verilog/dbu_top.v */
// debug breakpoint unit: breakpoints, watchpoints, cause capture, stop mask, scratch
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// [R1] record 3-bit debug cause, reset zero
// [R2] record lowest firing breakpoint index
// [R3] record causing thread, zero for host
// [R4] data watchpoint captures effective address
// [R5] resource watchpoint captures resource identifier
// [R6] stop mask halts threads outside debug
// [R7] eight shared scratch words
// [R8] four instruction breakpoints on PC match
// [R9] per-thread enable field, resets zero
// [R10] condition bit selects equal or unequal
// [R11] bit zero is master enable
// [R12] four data watchpoints, two addresses
// [R13] combine bit selects AND or OR
// [R14] load bit lets loads trigger
// [R15] four resource watchpoints, mask and value
// [R16] condition bit selects condition A or B
// [R17] all capture fields update together
// [R18] masked compare, parameterised A and B
`include "dbu_defs.vh"
module dbu_top #(
    parameter NBP      = 4,
    parameter NSCR     = 8,
    parameter RES_A_EQ = 1,
    parameter RES_B_EQ = 0
) (
    input  wire        core_clk_i,
    input  wire        reset_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire        hreadyout_o,
    output wire        hresp_o,
    output reg  [31:0] hrdata_o,
    input  wire        host_dbg_req_i,
    input  wire        debug_call_instruction_valid_i,
    input  wire [2:0]  debug_call_instruction_thread_i,
    input  wire        pc_valid_i,
    input  wire [31:0] pc_i,
    input  wire [2:0]  pc_thread_i,
    input  wire        mem_valid_i,
    input  wire        mem_load_i,
    input  wire [31:0] mem_addr_i,
    input  wire [2:0]  mem_thread_i,
    input  wire        res_valid_i,
    input  wire [31:0] res_id_i,
    input  wire [2:0]  res_thread_i,
    output wire        debug_mode_o,
    output reg         debug_entry_o,
    output wire [7:0]  thread_stop_o,
    output wire        irq_o
);

    reg  [31:0] scr_q  [0:NSCR-1];
    reg  [31:0] iba_q  [0:NBP-1];
    reg  [31:0] ibc_q  [0:NBP-1];
    reg  [31:0] dwa1_q [0:NBP-1];
    reg  [31:0] dwa2_q [0:NBP-1];
    reg  [31:0] dwc_q  [0:NBP-1];
    reg  [31:0] rwm_q  [0:NBP-1];
    reg  [31:0] rwv_q  [0:NBP-1];
    reg  [31:0] rwc_q  [0:NBP-1];
    reg  [2:0]  cause_q;
    reg  [1:0]  bidx_q;
    reg  [7:0]  thr_q;
    reg  [31:0] data_q;
    reg  [7:0]  stop_q;
    reg         dbg_q;
    reg  [4:0]  sts_q;
    reg  [4:0]  msk_q;
    reg         hreq_s1_q;
    reg         hreq_s2_q;
    reg         hreq_s3_q;
    reg         wr_q;
    reg         rd_q;
    reg         rd_done_q;
    reg  [7:0]  idx_q;
    wire [NBP-1:0] ib_hit;
    wire [NBP-1:0] dw_hit;
    wire [NBP-1:0] rw_hit;
    integer k;

    function [1:0] lowest;
        input [3:0] v;
        begin
            if (v[0]) lowest = 2'h0;
            else if (v[1]) lowest = 2'h1;
            else if (v[2]) lowest = 2'h2;
            else lowest = 2'h3;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NBP; g = g + 1) begin : g_bp
            wire pc_eq = (pc_i == iba_q[g]);
            wire a_ge  = (mem_addr_i >= dwa1_q[g]);
            wire b_le  = (mem_addr_i <= dwa2_q[g]);
            wire r_eq  = (((res_id_i ^ rwv_q[g]) & rwm_q[g]) == 32'h00000000);
            wire r_a   = RES_A_EQ ? r_eq : ~r_eq; // see [R18]
            wire r_b   = RES_B_EQ ? r_eq : ~r_eq; // see [R18]
            // see [R8] see [R9] see [R10] see [R11]
            assign ib_hit[g] = pc_valid_i & ibc_q[g][`DBU_EN_BIT]
                             & ibc_q[g][`DBU_TEN_LSB + pc_thread_i]
                             & (ibc_q[g][`DBU_COND_BIT] ? ~pc_eq : pc_eq);
            // stores always qualify; loads only with the load bit
            assign dw_hit[g] = mem_valid_i & dwc_q[g][`DBU_EN_BIT]
                             & dwc_q[g][`DBU_TEN_LSB + mem_thread_i]
                             & (~mem_load_i | dwc_q[g][`DBU_LOAD_BIT]) // see [R14]
                             & (dwc_q[g][`DBU_COND_BIT] ? (a_ge | b_le)
                                                        : (a_ge & b_le)); // see [R12] see [R13]
            assign rw_hit[g] = res_valid_i & rwc_q[g][`DBU_EN_BIT]
                             & rwc_q[g][`DBU_TEN_LSB + res_thread_i]
                             & (rwc_q[g][`DBU_COND_BIT] ? r_b : r_a); // see [R15] see [R16]
        end
    endgenerate

    // pad to the four slots the index field names; a zero repeat count is illegal
    wire [NBP+3:0] ib_x = {4'h0, ib_hit};
    wire [NBP+3:0] dw_x = {4'h0, dw_hit};
    wire [NBP+3:0] rw_x = {4'h0, rw_hit};
    wire [3:0]     ib_v = ib_x[3:0];
    wire [3:0]     dw_v = dw_x[3:0];
    wire [3:0]     rw_v = rw_x[3:0];

    wire host_ev  = hreq_s2_q & ~hreq_s3_q;
    wire any_ev   = host_ev | debug_call_instruction_valid_i | (|ib_hit) | (|dw_hit) | (|rw_hit);
    // no new entry while already in debug mode
    wire enter    = ~dbg_q & any_ev;

    reg  [2:0]  ev_cause;
    reg  [1:0]  ev_bidx;
    reg  [7:0]  ev_thr;
    reg  [31:0] ev_data;
    always @* begin
        ev_cause = `DBU_CAUSE_HOST;
        ev_bidx  = 2'h0;
        ev_thr   = 8'h00;
        ev_data  = data_q;
        if (host_ev) begin
            ev_cause = `DBU_CAUSE_HOST; // see [R1] see [R3]
        end else if (debug_call_instruction_valid_i) begin
            ev_cause = `DBU_CAUSE_DEBUG_CALL_INSTRUCTION;
            ev_thr   = {5'h00, debug_call_instruction_thread_i};
        end else if (|ib_hit) begin
            ev_cause = `DBU_CAUSE_IBP;
            ev_bidx  = lowest(ib_v); // see [R2]
            ev_thr   = {5'h00, pc_thread_i};
        end else if (|dw_hit) begin
            ev_cause = `DBU_CAUSE_DWP;
            ev_bidx  = lowest(dw_v);
            ev_thr   = {5'h00, mem_thread_i};
            ev_data  = mem_addr_i; // see [R4]
        end else begin
            ev_cause = `DBU_CAUSE_RWP;
            ev_bidx  = lowest(rw_v);
            ev_thr   = {5'h00, res_thread_i};
            ev_data  = res_id_i; // see [R5]
        end
    end

    // zero-wait writes, one wait state on reads so read data is registered
    wire take = hsel_i & hready_i & htrans_i[1];
    wire rd_wait = rd_q & ~rd_done_q;
    assign hreadyout_o = ~rd_wait;
    assign hresp_o     = `DBU_HRESP_OKAY;

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            rd_done_q <= 1'b0;
            idx_q     <= 8'h00;
        end else begin
            if (rd_wait) begin
                rd_done_q <= 1'b1;
            end else begin
                wr_q      <= take & hwrite_i;
                rd_q      <= take & ~hwrite_i;
                rd_done_q <= 1'b0;
                if (take)
                    idx_q <= haddr_i[9:2];
            end
        end
    end

    wire wr_en = wr_q;
    wire [2:0] sub8 = idx_q[2:0];
    wire [1:0] sub4 = idx_q[1:0];
    wire grp4 = (idx_q[7:2] == 6'h0C) || (idx_q[7:2] == 6'h10) ||
                (idx_q[7:2] == 6'h14) || (idx_q[7:2] == 6'h18) ||
                (idx_q[7:2] == 6'h1C) || (idx_q[7:2] == 6'h20) ||
                (idx_q[7:2] == 6'h24) || (idx_q[7:2] == 6'h27);

    reg [31:0] rmux;
    always @* begin
        rmux = 32'h00000000;
        case (idx_q)
            `DBU_IDX_CAUSE: rmux = {14'h0000, bidx_q, thr_q, 5'h00, cause_q};
            `DBU_IDX_DATA:  rmux = data_q;
            `DBU_IDX_STOP:  rmux = {24'h000000, stop_q};
            `DBU_IDX_STS:   rmux = {27'h0000000, sts_q};
            `DBU_IDX_MSK:   rmux = {27'h0000000, msk_q};
            `DBU_IDX_MODE:  rmux = {31'h00000000, dbg_q};
            default: begin
                if (idx_q[7:3] == 5'h04)
                    rmux = scr_q[sub8];
                else if (grp4) begin
                    case (idx_q[7:2])
                        6'h0C:   rmux = iba_q[sub4];
                        6'h10:   rmux = ibc_q[sub4];
                        6'h14:   rmux = dwa1_q[sub4];
                        6'h18:   rmux = dwa2_q[sub4];
                        6'h1C:   rmux = dwc_q[sub4];
                        6'h20:   rmux = rwm_q[sub4];
                        6'h24:   rmux = rwv_q[sub4];
                        6'h27:   rmux = rwc_q[sub4];
                        default: rmux = 32'h00000000;
                    endcase
                end
            end
        endcase
    end

    wire rd_now   = rd_wait;
    wire sts_rd   = rd_now & (idx_q == `DBU_IDX_STS);
    wire [4:0] sts_set = enter ? (5'h01 << (ev_cause - 3'h1)) : 5'h00;

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_o      <= `DBU_RST_WORD;
            hreq_s1_q     <= 1'b0;
            hreq_s2_q     <= 1'b0;
            hreq_s3_q     <= 1'b0;
            cause_q       <= `DBU_RST_CAUSE;
            bidx_q        <= 2'h0;
            thr_q         <= 8'h00;
            data_q        <= `DBU_RST_WORD;
            stop_q        <= 8'h00;
            dbg_q         <= 1'b0;
            sts_q         <= 5'h00;
            msk_q         <= 5'h00;
            debug_entry_o <= 1'b0;
            for (k = 0; k < NSCR; k = k + 1)
                scr_q[k] <= `DBU_RST_WORD;
            for (k = 0; k < NBP; k = k + 1) begin
                iba_q[k]  <= `DBU_RST_WORD;
                ibc_q[k]  <= `DBU_RST_CTL; // see [R9] see [R11]
                dwa1_q[k] <= `DBU_RST_WORD;
                dwa2_q[k] <= `DBU_RST_WORD;
                dwc_q[k]  <= `DBU_RST_CTL;
                rwm_q[k]  <= `DBU_RST_WORD;
                rwv_q[k]  <= `DBU_RST_WORD;
                rwc_q[k]  <= `DBU_RST_CTL;
            end
        end else begin
            hreq_s1_q     <= host_dbg_req_i;
            hreq_s2_q     <= hreq_s1_q;
            hreq_s3_q     <= hreq_s2_q;
            debug_entry_o <= enter;
            if (rd_now)
                hrdata_o <= rmux;
            // read clears, but a same-cycle event still lands
            sts_q <= (sts_rd ? 5'h00 : sts_q) | sts_set;
            if (wr_en) begin
                case (idx_q)
                    `DBU_IDX_CAUSE: begin
                        cause_q <= hwdata_i[2:0];
                        thr_q   <= hwdata_i[15:8];
                        bidx_q  <= hwdata_i[17:16];
                    end
                    `DBU_IDX_DATA: data_q <= hwdata_i;
                    `DBU_IDX_STOP: stop_q <= hwdata_i[7:0];
                    `DBU_IDX_MSK:  msk_q  <= hwdata_i[4:0];
                    // writing one leaves debug mode
                    `DBU_IDX_MODE: if (hwdata_i[0]) dbg_q <= 1'b0;
                    default: begin
                        if (idx_q[7:3] == 5'h04)
                            scr_q[sub8] <= hwdata_i; // see [R7]
                        else begin
                            case (idx_q[7:2])
                                6'h0C: iba_q[sub4]  <= hwdata_i;
                                6'h10: ibc_q[sub4]  <= hwdata_i & `DBU_CTL_WMASK;
                                6'h14: dwa1_q[sub4] <= hwdata_i;
                                6'h18: dwa2_q[sub4] <= hwdata_i;
                                6'h1C: dwc_q[sub4]  <= hwdata_i & `DBU_CTL_WMASK;
                                6'h20: rwm_q[sub4]  <= hwdata_i;
                                6'h24: rwv_q[sub4]  <= hwdata_i;
                                6'h27: rwc_q[sub4]  <= {8'h00, hwdata_i[23:16],
                                                        14'h0000, hwdata_i[1:0]};
                                default: ;
                            endcase
                        end
                    end
                endcase
            end
            // capture wins over a software write in the same cycle
            if (enter) begin
                dbg_q   <= 1'b1;
                cause_q <= ev_cause; // see [R17]
                bidx_q  <= ev_bidx;
                thr_q   <= ev_thr;
                data_q  <= ev_data;
            end
        end
    end

    assign debug_mode_o  = dbg_q;
    assign thread_stop_o = dbg_q ? 8'h00 : stop_q; // see [R6]
    assign irq_o         = |(sts_q & msk_q);

endmodule // dbu_top

/* tb/dbu_top_sva.sv */
// port-level assertions for the debug breakpoint unit
`timescale 1ns/1ps
module dbu_top_sva (
    input wire       core_clk_i,
    input wire       reset_i,
    input wire       hsel_i,
    input wire [1:0] htrans_i,
    input wire       hwrite_i,
    input wire       hready_i,
    input wire       hreadyout_o,
    input wire       hresp_o,
    input wire       host_dbg_req_i,
    input wire       debug_call_instruction_valid_i,
    input wire       pc_valid_i,
    input wire       mem_valid_i,
    input wire       res_valid_i,
    input wire       debug_mode_o,
    input wire       debug_entry_o,
    input wire [7:0] thread_stop_o
);
    wire take_w = hsel_i & hready_i & htrans_i[1];
    // host pin reaches entry three edges late through its synchroniser, so kept apart
    wire hit_w  = debug_call_instruction_valid_i | pc_valid_i | mem_valid_i | res_valid_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    okay_resp_a: assert property (hresp_o == 1'b0) else $error("response not okay");
    read_wait_a: assert property (take_w && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read data phase not two cycles");
    write_nowait_a: assert property (take_w && hwrite_i |=> hreadyout_o)
        else $error("write data phase stalled");
    entry_pulse_a: assert property (debug_entry_o |=> !debug_entry_o)
        else $error("entry pulse longer than one cycle");
    entry_mode_a: assert property ($rose(debug_mode_o) |-> debug_entry_o)
        else $error("debug entry without pulse");
    debug_call_instruction_entry_a: assert property (debug_call_instruction_valid_i && !debug_mode_o |=> debug_mode_o)
        else $error("debug call ignored");
    host_entry_a: assert property ($rose(host_dbg_req_i) && !debug_mode_o
        |-> ##[1:4] debug_mode_o) else $error("host request ignored");
    entry_cause_a: assert property ($rose(debug_mode_o) |->
        $past(hit_w) || $past(host_dbg_req_i, 3)) else $error("debug entry without event");
    stop_hidden_a: assert property (debug_mode_o |-> thread_stop_o == 8'h00)
        else $error("threads stopped inside debug mode");
endmodule // dbu_top_sva
bind dbu_top dbu_top_sva u_dbu_top_sva (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .host_dbg_req_i(host_dbg_req_i),
    .debug_call_instruction_valid_i(debug_call_instruction_valid_i), .pc_valid_i(pc_valid_i), .mem_valid_i(mem_valid_i),
    .res_valid_i(res_valid_i), .debug_mode_o(debug_mode_o), .debug_entry_o(debug_entry_o),
    .thread_stop_o(thread_stop_o));

/* tb/dbu_core_model.sv */
// processor core model issuing debug-relevant events one cycle at a time
`timescale 1ns/1ps
module dbu_core_model (
    input  wire        core_clk_i,
    input  wire  [7:0] thread_stop_i,
    output logic [3:0] vld_o,
    output logic [2:0] thr_o,
    output logic [31:0] val_o,
    output logic       ld_o
);
    initial begin
        vld_o = 4'h0;
        thr_o = 3'h0;
        val_o = 32'h0;
        ld_o  = 1'b0;
    end
    // kinds: 0 debug call, 1 fetch, 2 memory, 3 resource; called just after an edge
    task automatic issue(input logic [1:0] k, input logic [2:0] t, input logic [31:0] v,
                         input logic l);
        if (!thread_stop_i[t]) begin
            vld_o <= 4'h1 << k;
        end
        thr_o <= t;
        val_o <= v;
        ld_o  <= l;
        @(posedge core_clk_i);
        // idle lines flip so a stale value is never mistaken for a live one
        vld_o <= 4'h0;
        thr_o <= ~t;
        val_o <= ~v;
        ld_o  <= ~l;
    endtask
endmodule // dbu_core_model

/* tb/dbu_top_test.sv */
// self-checking bench for the debug breakpoint unit
`timescale 1ns/1ps
`include "dbu_defs.vh"
module dbu_top_test;
    logic        core_clk_i, reset_i, hsel, hwrite, host_req;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, rd;
    wire         hreadyout, hresp, dbg_mode, dbg_entry, irq, ld;
    wire  [31:0] hrdata, val;
    wire  [7:0]  stop;
    wire  [3:0]  vld;
    wire  [2:0]  thr;
    int          n_errors = 0, check_count = 0, cyc = 0;
    dbu_top u_dbu_top (.core_clk_i(core_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .host_dbg_req_i(host_req), .debug_call_instruction_valid_i(vld[0]), .debug_call_instruction_thread_i(thr),
        .pc_valid_i(vld[1]), .pc_i(val), .pc_thread_i(thr), .mem_valid_i(vld[2]),
        .mem_load_i(ld), .mem_addr_i(val), .mem_thread_i(thr), .res_valid_i(vld[3]),
        .res_id_i(val), .res_thread_i(thr), .debug_mode_o(dbg_mode),
        .debug_entry_o(dbg_entry), .thread_stop_o(stop), .irq_o(irq));
    dbu_core_model u_dbu_core_model (.core_clk_i(core_clk_i), .thread_stop_i(stop),
        .vld_o(vld), .thr_o(thr), .val_o(val), .ld_o(ld));
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            complete_run;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= `DBU_HTRANS_NSEQ;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'h0};
        @(posedge core_clk_i);
        while (hreadyout !== 1'b1) @(posedge core_clk_i);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk_i);
        while (hreadyout !== 1'b1) @(posedge core_clk_i);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(nm, exp, rd);
    endtask
    // issue one event, give it two edges to land, then compare the mode
    task automatic ev(input logic [1:0] k, input logic [2:0] t, input logic [31:0] v,
                      input logic l, input logic m);
        u_dbu_core_model.issue(k, t, v, l);
        repeat (2) @(posedge core_clk_i);
        chk("debug_mode", {31'h0, m}, {31'h0, dbg_mode});
    endtask
    initial begin
        reset_i <= 1'b1;
        {hsel, hwrite, host_req, htrans, haddr, hwdata} <= '0;
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        rdc("cause", `DBU_IDX_CAUSE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rdc("ibc", 8'(`DBU_IDX_IBC + i), `DBU_RST_CTL);
            rdc("dwc", 8'(`DBU_IDX_DWC + i), `DBU_RST_CTL);
            rdc("rwc", 8'(`DBU_IDX_RWC + i), `DBU_RST_CTL);
        end
        for (int i = 0; i < 8; i++) wr(8'(`DBU_IDX_SCR + i), 32'hA5C30000 | i);
        for (int i = 0; i < 8; i++) begin
            rdc("scratch", 8'(`DBU_IDX_SCR + i), 32'hA5C30000 | i);
        end
        wr(8'h10, 32'hFFFFFFFF);
        rdc("unmapped", 8'h10, 32'h0);
        wr(`DBU_IDX_IBC + 8'h3, 32'hFFFFFFFF);
        rdc("ibc_bits", `DBU_IDX_IBC + 8'h3, 32'h00FF0007);
        wr(`DBU_IDX_RWC + 8'h3, 32'hFFFFFFFF);
        rdc("rwc_bits", `DBU_IDX_RWC + 8'h3, 32'h00FF0003);
        // all-ones ibc 3 would fire on any fetch with PC not 0 (rwc 3 with a zero mask never fires), so put them back
        wr(`DBU_IDX_IBC + 8'h3, 32'h0);
        wr(`DBU_IDX_RWC + 8'h3, 32'h0);
        wr(`DBU_IDX_MSK, 32'h1F);
        wr(`DBU_IDX_IBA + 8'h1, 32'h0);
        wr(`DBU_IDX_IBC + 8'h1, 32'h00080003);
        wr(`DBU_IDX_IBA + 8'h2, 32'h1000);
        wr(`DBU_IDX_IBC + 8'h2, 32'h00080001);
        ev(2'd1, 3'd2, 32'h1000, 1'b0, 1'b0);
        ev(2'd1, 3'd3, 32'h1000, 1'b0, 1'b1);
        rdc("cause", `DBU_IDX_CAUSE, 32'h00010303);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("status", `DBU_IDX_STS, 32'h4);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`DBU_IDX_MODE, 32'h1);
        wr(`DBU_IDX_IBC + 8'h1, 32'h0);
        wr(`DBU_IDX_IBC + 8'h2, 32'h0);
        wr(`DBU_IDX_DWA1 + 8'h1, 32'h200);
        wr(`DBU_IDX_DWA2 + 8'h1, 32'h300);
        wr(`DBU_IDX_DWC + 8'h1, 32'h00010001);
        ev(2'd2, 3'd0, 32'h250, 1'b1, 1'b0);
        ev(2'd2, 3'd0, 32'h100, 1'b0, 1'b0);
        wr(`DBU_IDX_DWC + 8'h1, 32'h00010003);
        ev(2'd2, 3'd0, 32'h100, 1'b0, 1'b1);
        rdc("cause", `DBU_IDX_CAUSE, 32'h00010004);
        rdc("data", `DBU_IDX_DATA, 32'h100);
        wr(`DBU_IDX_MODE, 32'h1);
        wr(`DBU_IDX_DWC + 8'h1, 32'h00010005);
        ev(2'd2, 3'd0, 32'h250, 1'b1, 1'b1);
        rdc("data", `DBU_IDX_DATA, 32'h250);
        wr(`DBU_IDX_MODE, 32'h1);
        wr(`DBU_IDX_DWC + 8'h1, 32'h0);
        wr(`DBU_IDX_RWM, 32'hFF);
        wr(`DBU_IDX_RWV, 32'h42);
        wr(`DBU_IDX_RWC, 32'h00200001);
        ev(2'd3, 3'd5, 32'h1143, 1'b0, 1'b0);
        ev(2'd3, 3'd5, 32'h1142, 1'b0, 1'b1);
        rdc("cause", `DBU_IDX_CAUSE, 32'h00000505);
        rdc("data", `DBU_IDX_DATA, 32'h1142);
        wr(`DBU_IDX_MODE, 32'h1);
        wr(`DBU_IDX_RWC, 32'h00200003);
        ev(2'd3, 3'd5, 32'h1142, 1'b0, 1'b0);
        ev(2'd3, 3'd5, 32'h1143, 1'b0, 1'b1);
        rdc("data", `DBU_IDX_DATA, 32'h1143);
        wr(`DBU_IDX_MODE, 32'h1);
        wr(`DBU_IDX_RWC, 32'h0);
        wr(`DBU_IDX_STOP, 32'h10);
        // the write lands on the edge the task returns at; look one edge later
        @(posedge core_clk_i);
        chk("stop", 32'h10, {24'h0, stop});
        ev(2'd0, 3'd7, 32'h0, 1'b0, 1'b1);
        chk("stop", 32'h0, {24'h0, stop});
        rdc("cause", `DBU_IDX_CAUSE, 32'h00000702);
        wr(`DBU_IDX_MODE, 32'h1);
        repeat (2) @(posedge core_clk_i);
        chk("stop", 32'h10, {24'h0, stop});
        host_req <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        chk("debug_mode", 32'h1, {31'h0, dbg_mode});
        rdc("cause", `DBU_IDX_CAUSE, 32'h00000001);
        host_req <= 1'b0;
        wr(`DBU_IDX_MODE, 32'h1);
        complete_run;
    end
endmodule // dbu_top_test
